/* bstap_pkg.sv */
`default_nettype none

package bstap_pkg;

	// ----------------------------------------------------------------
	// scan geometry and fixed values
	// ----------------------------------------------------------------
	localparam int IR_W = 8;
	localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 8'h81;
	localparam logic [IR_W-1:0] IR_BYPASS = 8'hff;
	localparam int NF_W = 8;
	localparam logic [NF_W-1:0] NF_RESET_VAL = 8'h00;
	localparam logic BYPASS_CAPTURE_VAL = 1'h0;
	localparam int SYNC_STAGES = 2;

	// ----------------------------------------------------------------
	// tap controller states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		TAP_RESET = 4'h0,
		TAP_IDLE = 4'h1,
		TAP_SEL_DR = 4'h2,
		TAP_CAP_DR = 4'h3,
		TAP_SHIFT_DR = 4'h4,
		TAP_EXIT1_DR = 4'h5,
		TAP_PAUSE_DR = 4'h6,
		TAP_EXIT2_DR = 4'h7,
		TAP_UPD_DR = 4'h8,
		TAP_SEL_IR = 4'h9,
		TAP_CAP_IR = 4'ha,
		TAP_SHIFT_IR = 4'hb,
		TAP_EXIT1_IR = 4'hc,
		TAP_PAUSE_IR = 4'hd,
		TAP_EXIT2_IR = 4'he,
		TAP_UPD_IR = 4'hf
	} bstap_state_t;

	// status levels handed from the test clock to the system clock
	typedef struct packed {
		logic test_reset;
		logic bypass_sel;
	} bstap_status_t;

	localparam bstap_status_t STATUS_RESET_VAL = 2'h0;
	// tck side source after reset: logic reset with bypass selected
	localparam bstap_status_t STATUS_TLR_VAL = 2'h3;

endpackage

`default_nettype wire

/* bstap_core.sv */
`default_nettype none

module bstap_core (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo_o,
	output logic tdo_oe,
	input wire logic [bstap_pkg::NF_W-1:0] nf_in,
	output logic [bstap_pkg::NF_W-1:0] nf_test_out,
	output bstap_pkg::bstap_status_t sys_status
);

	// ----------------------------------------------------------------
	// tap state machine (rising tck)
	// ----------------------------------------------------------------
	bstap_pkg::bstap_state_t state_reg;
	bstap_pkg::bstap_state_t state_next;

	// graph decode, tms steers every arc
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			bstap_pkg::TAP_RESET: state_next = tms ? bstap_pkg::TAP_RESET : bstap_pkg::TAP_IDLE;
			bstap_pkg::TAP_IDLE: state_next = tms ? bstap_pkg::TAP_SEL_DR : bstap_pkg::TAP_IDLE;
			bstap_pkg::TAP_SEL_DR: state_next = tms ? bstap_pkg::TAP_SEL_IR : bstap_pkg::TAP_CAP_DR;
			bstap_pkg::TAP_CAP_DR: state_next = tms ? bstap_pkg::TAP_EXIT1_DR : bstap_pkg::TAP_SHIFT_DR;
			bstap_pkg::TAP_SHIFT_DR: state_next = tms ? bstap_pkg::TAP_EXIT1_DR : bstap_pkg::TAP_SHIFT_DR;
			bstap_pkg::TAP_EXIT1_DR: state_next = tms ? bstap_pkg::TAP_UPD_DR : bstap_pkg::TAP_PAUSE_DR;
			bstap_pkg::TAP_PAUSE_DR: state_next = tms ? bstap_pkg::TAP_EXIT2_DR : bstap_pkg::TAP_PAUSE_DR;
			bstap_pkg::TAP_EXIT2_DR: state_next = tms ? bstap_pkg::TAP_UPD_DR : bstap_pkg::TAP_SHIFT_DR;
			bstap_pkg::TAP_UPD_DR: state_next = tms ? bstap_pkg::TAP_SEL_DR : bstap_pkg::TAP_IDLE;
			bstap_pkg::TAP_SEL_IR: state_next = tms ? bstap_pkg::TAP_RESET : bstap_pkg::TAP_CAP_IR;
			bstap_pkg::TAP_CAP_IR: state_next = tms ? bstap_pkg::TAP_EXIT1_IR : bstap_pkg::TAP_SHIFT_IR;
			bstap_pkg::TAP_SHIFT_IR: state_next = tms ? bstap_pkg::TAP_EXIT1_IR : bstap_pkg::TAP_SHIFT_IR;
			bstap_pkg::TAP_EXIT1_IR: state_next = tms ? bstap_pkg::TAP_UPD_IR : bstap_pkg::TAP_PAUSE_IR;
			bstap_pkg::TAP_PAUSE_IR: state_next = tms ? bstap_pkg::TAP_EXIT2_IR : bstap_pkg::TAP_PAUSE_IR;
			bstap_pkg::TAP_EXIT2_IR: state_next = tms ? bstap_pkg::TAP_UPD_IR : bstap_pkg::TAP_SHIFT_IR;
			bstap_pkg::TAP_UPD_IR: state_next = tms ? bstap_pkg::TAP_SEL_DR : bstap_pkg::TAP_IDLE;
		endcase
	end

	// tms is sampled straight on tck, it is already in this domain
	always_ff @(posedge tck or negedge resetn) begin
		if (!resetn) begin
			state_reg <= bstap_pkg::TAP_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// shift stages (rising tck)
	// ----------------------------------------------------------------
	logic [bstap_pkg::IR_W-1:0] ir_shift_reg;
	logic [bstap_pkg::IR_W-1:0] ir_shift_next;
	logic bypass_reg;
	logic bypass_next;
	logic [bstap_pkg::NF_W-1:0] dr_shift_reg;
	logic [bstap_pkg::NF_W-1:0] dr_shift_next;
	logic [bstap_pkg::IR_W-1:0] ir_active_reg;
	logic bypass_sel;

	// any code other than all ones picks the input sample register
	assign bypass_sel = (ir_active_reg == bstap_pkg::IR_BYPASS);

	// capture on the edge leaving capture, lsb first out, tdi into msb
	always_comb begin
		ir_shift_next = ir_shift_reg;
		bypass_next = bypass_reg;
		dr_shift_next = dr_shift_reg;
		if (state_reg == bstap_pkg::TAP_CAP_IR) begin
			ir_shift_next = bstap_pkg::IR_CAPTURE_VAL;
		end else if (state_reg == bstap_pkg::TAP_SHIFT_IR) begin
			ir_shift_next = {tdi, ir_shift_reg[bstap_pkg::IR_W-1:1]};
		end
		if (state_reg == bstap_pkg::TAP_CAP_DR) begin
			if (bypass_sel) begin
				bypass_next = bstap_pkg::BYPASS_CAPTURE_VAL;
			end else begin
				dr_shift_next = nf_in;
			end
		end else if (state_reg == bstap_pkg::TAP_SHIFT_DR) begin
			if (bypass_sel) begin
				bypass_next = tdi;
			end else begin
				dr_shift_next = {tdi, dr_shift_reg[bstap_pkg::NF_W-1:1]};
			end
		end
	end

	always_ff @(posedge tck or negedge resetn) begin
		if (!resetn) begin
			ir_shift_reg <= bstap_pkg::IR_CAPTURE_VAL;
			bypass_reg <= bstap_pkg::BYPASS_CAPTURE_VAL;
			dr_shift_reg <= bstap_pkg::NF_RESET_VAL;
		end else begin
			ir_shift_reg <= ir_shift_next;
			bypass_reg <= bypass_next;
			dr_shift_reg <= dr_shift_next;
		end
	end

	// ----------------------------------------------------------------
	// output and update stages (falling tck)
	// ----------------------------------------------------------------
	logic tdo_reg;
	logic tdo_next;
	logic tdo_oe_reg;
	logic tdo_oe_next;
	logic [bstap_pkg::IR_W-1:0] ir_active_next;
	logic [bstap_pkg::NF_W-1:0] nf_par_reg;
	logic [bstap_pkg::NF_W-1:0] nf_par_next;
	logic in_shift;
	bstap_pkg::bstap_status_t status_reg;
	bstap_pkg::bstap_status_t status_next;

	assign in_shift = (state_reg == bstap_pkg::TAP_SHIFT_IR) ||
		(state_reg == bstap_pkg::TAP_SHIFT_DR);

	// half a cycle after the state settles, so the far end samples clean data
	always_comb begin
		tdo_next = tdo_reg;
		tdo_oe_next = in_shift;
		ir_active_next = ir_active_reg;
		nf_par_next = nf_par_reg;
		if (state_reg == bstap_pkg::TAP_SHIFT_IR) begin
			tdo_next = ir_shift_reg[0];
		end else if (state_reg == bstap_pkg::TAP_SHIFT_DR) begin
			tdo_next = bypass_sel ? bypass_reg : dr_shift_reg[0];
		end
		if (state_reg == bstap_pkg::TAP_RESET) begin
			ir_active_next = bstap_pkg::IR_BYPASS;
		end else if (state_reg == bstap_pkg::TAP_UPD_IR) begin
			ir_active_next = ir_shift_reg;
		end
		if (state_reg == bstap_pkg::TAP_UPD_DR && !bypass_sel) begin
			nf_par_next = dr_shift_reg;
		end
		// registered so the crossing never sees a decoder glitch
		status_next.test_reset = (state_reg == bstap_pkg::TAP_RESET);
		status_next.bypass_sel = (ir_active_next == bstap_pkg::IR_BYPASS);
	end

	always_ff @(negedge tck or negedge resetn) begin
		if (!resetn) begin
			tdo_reg <= 1'h0;
			tdo_oe_reg <= 1'h0;
			ir_active_reg <= bstap_pkg::IR_BYPASS;
			nf_par_reg <= bstap_pkg::NF_RESET_VAL;
			status_reg <= bstap_pkg::STATUS_TLR_VAL;
		end else begin
			tdo_reg <= tdo_next;
			tdo_oe_reg <= tdo_oe_next;
			ir_active_reg <= ir_active_next;
			nf_par_reg <= nf_par_next;
			status_reg <= status_next;
		end
	end

	assign tdo_o = tdo_reg;
	assign tdo_oe = tdo_oe_reg;
	assign nf_test_out = nf_par_reg;

	// ----------------------------------------------------------------
	// status crossing into the system clock
	// ----------------------------------------------------------------
	bstap_pkg::bstap_status_t status_src;
	bstap_pkg::bstap_status_t sync1_reg;
	bstap_pkg::bstap_status_t sync1_next;
	bstap_pkg::bstap_status_t sync2_reg;
	bstap_pkg::bstap_status_t sync2_next;

	// both fields are slow levels, so bitwise two-flop sync is enough
	// source comes straight from a flop, never from decode logic
	assign status_src = status_reg;

	always_comb begin
		sync1_next = sync1_reg;
		sync2_next = sync2_reg;
		if (ce) begin
			sync1_next = status_src;
			sync2_next = sync1_reg;
		end
	end

	// ce freezes everything on the system clock side
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sync1_reg <= bstap_pkg::STATUS_RESET_VAL;
			sync2_reg <= bstap_pkg::STATUS_RESET_VAL;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
		end
	end

	assign sys_status = sync2_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_IR_CAPTURE: assert property (@(posedge tck) disable iff (!resetn)
		state_reg == bstap_pkg::TAP_CAP_IR |=> ir_shift_reg == 8'h81)
		else $error("ir did not capture fixed pattern");

	AST_IR_SHIFT: assert property (@(posedge tck) disable iff (!resetn)
		state_reg == bstap_pkg::TAP_SHIFT_IR |=>
		ir_shift_reg == {$past(tdi), $past(ir_shift_reg[7:1])})
		else $error("ir shift moved wrong bits");

	AST_TDO_DATA: assert property (@(posedge tck) disable iff (!resetn)
		state_reg == bstap_pkg::TAP_SHIFT_IR |-> tdo_reg == ir_shift_reg[0])
		else $error("tdo not showing ir lsb");

	AST_OE_SHIFT: assert property (@(posedge tck) disable iff (!resetn)
		in_shift |-> tdo_oe_reg)
		else $error("tdo not driven while shifting");

	AST_OE_EXIT: assert property (@(posedge tck) disable iff (!resetn)
		(state_reg == bstap_pkg::TAP_EXIT1_IR || state_reg == bstap_pkg::TAP_EXIT1_DR)
		|-> !tdo_oe_reg)
		else $error("tdo still driven in exit1");

	AST_IR_UPDATE: assert property (@(posedge tck) disable iff (!resetn)
		state_reg == bstap_pkg::TAP_UPD_IR |=> ir_active_reg == $past(ir_shift_reg))
		else $error("instruction not updated");

	AST_BYP_CAPTURE: assert property (@(posedge tck) disable iff (!resetn)
		state_reg == bstap_pkg::TAP_CAP_DR && bypass_sel |=> bypass_reg == 1'h0)
		else $error("bypass did not capture zero");

	AST_BYP_DELAY: assert property (@(posedge tck) disable iff (!resetn)
		state_reg == bstap_pkg::TAP_SHIFT_DR && bypass_sel ##1
		state_reg == bstap_pkg::TAP_SHIFT_DR |-> tdo_reg == $past(tdi))
		else $error("bypass path not one bit delay");

	AST_DR_UPDATE: assert property (@(posedge tck) disable iff (!resetn)
		state_reg == bstap_pkg::TAP_UPD_DR && !bypass_sel |=> nf_par_reg == $past(dr_shift_reg))
		else $error("parallel stage not updated");

	AST_TMS_RESET: assert property (@(posedge tck) disable iff (!resetn)
		tms [*5] |=> state_reg == bstap_pkg::TAP_RESET)
		else $error("five tms ones did not reach reset");

	AST_RESET_EXIT: assert property (@(posedge tck) disable iff (!resetn)
		state_reg == bstap_pkg::TAP_RESET && !tms |=> state_reg == bstap_pkg::TAP_IDLE)
		else $error("tms low did not leave reset");

	// sample register path, the one the bypass checks never reach
	AST_DR_CAPTURE: assert property (@(posedge tck) disable iff (!resetn)
		state_reg == bstap_pkg::TAP_CAP_DR && !bypass_sel |=> dr_shift_reg == $past(nf_in))
		else $error("sample register did not capture inputs");

	AST_DR_SHIFT: assert property (@(posedge tck) disable iff (!resetn)
		state_reg == bstap_pkg::TAP_SHIFT_DR && !bypass_sel |=>
		dr_shift_reg == {$past(tdi), $past(dr_shift_reg[7:1])})
		else $error("dr shift moved wrong bits");

	AST_TDO_DR: assert property (@(posedge tck) disable iff (!resetn)
		state_reg == bstap_pkg::TAP_SHIFT_DR && !bypass_sel |-> tdo_reg == dr_shift_reg[0])
		else $error("tdo not showing sample lsb");

	// driver enable must follow the shift states exactly, half a tck late
	AST_OE_MATCH: assert property (@(posedge tck) disable iff (!resetn)
		tdo_oe_reg == in_shift)
		else $error("tdo enable out of step with shift");

	// test outputs may only move in update-dr
	AST_NF_HOLD: assert property (@(posedge tck) disable iff (!resetn)
		$changed(nf_par_reg) |-> state_reg == bstap_pkg::TAP_UPD_DR)
		else $error("test outputs moved outside update");

	AST_IR_HOLD: assert property (@(posedge tck) disable iff (!resetn)
		$changed(ir_active_reg) |->
		(state_reg == bstap_pkg::TAP_UPD_IR || state_reg == bstap_pkg::TAP_RESET))
		else $error("instruction moved outside update");

endmodule

`default_nettype wire

/* bstap_ctl.sv */
`default_nettype none

module bstap_ctl (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo_w,
	input wire logic tdo_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------------------------------
	// test controller model
	// ----------------------------------------------------------------
	// tck stands low between frames, so nothing moves while idle
	initial begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h0;
	end

	// one tck period; o/oe show the state entered by the previous call
	task automatic step(input logic m, input logic d, output logic o, output logic oe);
		tms = m;
		tdi = d;
		#14;
		o = tdo_w;
		oe = tdo_oe;
		#1 tck = 1'h1;
		#15 tck = 1'h0;
	endtask

	// full scan from idle back to idle, lsb first
	task automatic scan(input logic ir, input logic [7:0] din, input int n,
		output logic [7:0] dout, output logic oe_sh, output logic oe_ex);
		logic o;
		logic oe;
		step(1'h1, 1'h0, o, oe);
		if (ir) begin
			step(1'h1, 1'h0, o, oe);
		end
		step(1'h0, 1'h0, o, oe);
		step(1'h0, 1'h0, o, oe);
		dout = 8'h00;
		oe_sh = 1'h1;
		for (int k = 0; k < n; k++) begin
			step(k == n - 1, din[k], o, oe);
			dout[k] = o;
			oe_sh = oe_sh & oe;
		end
		step(1'h1, 1'h0, o, oe);
		oe_ex = oe;
		step(1'h0, 1'h0, o, oe);
	endtask
endmodule

`default_nettype wire

/* tb.sv */
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk, resetn, ce, tdo_o, tdo_oe;
	logic [7:0] nf_in, nf_test_out;
	bstap_pkg::bstap_status_t sys_status;
	wire tck, tms, tdi, tdo_w;
	int error_cnt, cmp_count, cyc;
	logic [31:0] seed;

	// released line shows the inverse of its last value, never a stale bit
	assign tdo_w = tdo_oe ? tdo_o : ~tdo_o;

	bstap_core u_bstap_core (.clk(clk), .resetn(resetn), .ce(ce), .tck(tck), .tms(tms),
		.tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .nf_in(nf_in),
		.nf_test_out(nf_test_out), .sys_status(sys_status));
	bstap_ctl u_bstap_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo_w(tdo_w), .tdo_oe(tdo_oe));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	always #4 clk = ~clk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// bypass: a captured zero first, then each bit one shift late
	function automatic logic [7:0] exp_bypass(input logic [7:0] din, input int n);
		logic [7:0] m;
		m = 8'hff >> (8 - n);
		return {din[6:0], 1'h0} & m;
	endfunction

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			conclude();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] d, q, sav;
		logic o, oe, oe_sh, oe_ex;
		int n;
		clk = 1'h0;
		resetn = 1'h0;
		ce = 1'h0;
		nf_in = 8'h00;
		seed = 32'h00000fad;
		fork
			u_bstap_ctl.step(1'h1, 1'h0, o, oe);
			repeat (4) @(negedge clk);
		join
		resetn = 1'h1;
		repeat (4) @(negedge clk);
		chk(8'(tdo_oe), 8'h00);
		chk(nf_test_out, 8'h00);
		u_bstap_ctl.step(1'h0, 1'h0, o, oe);
		// new instruction while the status sync is frozen
		seed = xs(seed);
		u_bstap_ctl.scan(1'h1, seed[7:0] & 8'h7f, 8, q, oe_sh, oe_ex);
		chk(q, 8'h81);
		chk(8'(oe_sh), 8'h01);
		chk(8'(oe_ex), 8'h00);
		repeat (4) @(negedge clk);
		chk(8'(sys_status), 8'h00);
		ce = 1'h1;
		repeat (4) @(negedge clk);
		chk(8'(sys_status), 8'h00);
		// sample/update rounds on random data
		for (int r = 0; r < 3; r++) begin
			seed = xs(seed);
			nf_in = seed[15:8];
			d = seed[7:0];
			u_bstap_ctl.scan(1'h0, d, 8, q, oe_sh, oe_ex);
			chk(q, nf_in);
			chk(nf_test_out, d);
			chk(8'(oe_sh), 8'h01);
			chk(8'(oe_ex), 8'h00);
			sav = d;
		end
		u_bstap_ctl.scan(1'h1, 8'hff, 8, q, oe_sh, oe_ex);
		repeat (4) @(negedge clk);
		chk(8'(sys_status), 8'h01);
		// bypass: 101 corner first, then random lengths
		for (int r = 0; r < 4; r++) begin
			seed = xs(seed);
			n = (r == 0) ? 3 : 4 + int'(seed[9:8]);
			d = (r == 0) ? 8'h05 : seed[7:0];
			u_bstap_ctl.scan(1'h0, d, n, q, oe_sh, oe_ex);
			chk(q, exp_bypass(d, n));
			chk(8'(oe_sh), 8'h01);
			chk(8'(oe_ex), 8'h00);
			chk(nf_test_out, sav);
		end
		// leave a non-bypass instruction so logic reset has work to undo
		seed = xs(seed);
		u_bstap_ctl.scan(1'h1, seed[7:0] & 8'h7f, 8, q, oe_sh, oe_ex);
		chk(q, bstap_pkg::IR_CAPTURE_VAL);
		repeat (4) @(negedge clk);
		chk(8'(sys_status), 8'h00);
		repeat (5) u_bstap_ctl.step(1'h1, 1'h0, o, oe);
		repeat (4) @(negedge clk);
		chk(8'(sys_status), 8'h03);
		conclude();
	end
endmodule

`default_nettype wire
